// ===== verilog/spfc_pkg.sv
// package of constants and carriers for the self-program flash control block
// Contract
// RQ1 - request ready interrupt when enable bit, global flag set and store_enable clear
// RQ2 - set section busy when erase or write to read-while-write section starts
// RQ3 - clear section busy on re-enable store after programming finished
// RQ4 - clear section busy when a page buffer load starts
// RQ5 - re-enable plus store_enable, store within four cycles re-enables section reads
// RQ6 - refuse re-enable while erase or write still in progress
// RQ7 - re-enable during buffer load aborts load and clears page buffer
// RQ8 - boot-lock-set store programs lock bits from working register zero
// RQ9 - load within three cycles of boot-lock-set returns lock or fuse bits
// RQ10 - page write store writes buffer into page from pointer upper bits
// RQ11 - page erase store erases page from pointer upper bits
// RQ12 - write, erase, lock-set bits clear on completion or four-cycle timeout
// RQ13 - stall core through erase or write of no-read-while-write section
// RQ14 - store_enable alone loads word into buffer at pointer word address
// RQ15 - store_enable lasts four cycles, clears after store or expiry
// RQ16 - store_enable stays one until erase or write completes
// RQ17 - only five legal low-bit patterns take effect; bit 5 reads zero
// RQ18 - six lock bits default one, programming writes zero only
// RQ19 - general lock modes forbid external programming and verification
// RQ20 - application lock 10 or 00 rejects stores to application section
// RQ21 - application lock 00 or 01 blocks boot reads of app, masks interrupts
// RQ22 - software waits for store_enable clear before re-enable and reading
// RQ23 - boot lock field behaves the same for the boot section
// RQ24 - arming window counts core cycles after the write, cleared by reset
package spfc_pkg;
	// register map over apb
	localparam logic [7:0] SPFC_CTRL_OFF = 8'h00;
	localparam logic [7:0] SPFC_LOCK_OFF = 8'h04;
	localparam logic [7:0] SPFC_PTR_OFF = 8'h08;
	localparam logic [7:0] SPFC_DATA_OFF = 8'h0c;
	localparam logic [7:0] SPFC_FUSE_OFF = 8'h10;
	localparam logic [7:0] SPFC_STAT_OFF = 8'h14;
	// control bit positions
	localparam int SPFC_B_IE = 7;
	localparam int SPFC_B_BUSY = 6;
	localparam int SPFC_B_RE = 4;
	localparam int SPFC_B_BLS = 3;
	localparam int SPFC_B_PW = 2;
	localparam int SPFC_B_PE = 1;
	localparam int SPFC_B_SE = 0;
	// legal low five bit patterns
	localparam logic [4:0] SPFC_P_RE = 5'h11;
	localparam logic [4:0] SPFC_P_BLS = 5'h09;
	localparam logic [4:0] SPFC_P_PW = 5'h05;
	localparam logic [4:0] SPFC_P_PE = 5'h03;
	localparam logic [4:0] SPFC_P_SE = 5'h01;
	// reset values
	localparam logic [7:0] SPFC_CTRL_RST = 8'h00;
	localparam logic [5:0] SPFC_LOCK_RST = 6'h3f;
	// windows in core cycles
	localparam logic [2:0] SPFC_ARM_CYC = 3'h4;
	localparam logic [2:0] SPFC_LPM_CYC = 3'h3;
	// programming time
	localparam int SPFC_PROG_US = 3700;
	localparam int SPFC_CLK_MHZ = 40;
	localparam int SPFC_PROG_CYC = SPFC_PROG_US * SPFC_CLK_MHZ;
	// rww section ends below this word address
	localparam logic [11:0] SPFC_NO_READ_WHILE_WRITE_SECTION_START = 12'hc00;
	// sequencer states
	typedef enum {SPFC_IDLE, SPFC_ARMED, SPFC_PROG} spfc_state_t;
	// core store/load request
	typedef struct packed
	{
		logic store;
		logic load;
		logic [15:0] ptr;
		logic [15:0] word;
		logic from_boot;
	} spfc_req_t;
endpackage : spfc_pkg

// ===== verilog/spfc_ctrl.sv
// self-program flash control: control register, sequencer and lock checks
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module spfc_ctrl
	import spfc_pkg::*;
#(
	parameter int PROG_CYC = SPFC_PROG_CYC,
	parameter int PAGE_WORDS = 32
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// core side
	input wire logic global_int_en,
	input wire logic exec_in_boot,
	input wire logic vec_in_boot,
	input wire logic rww_read,
	output logic ready_irq,
	output logic core_stall,
	output logic rww_blocked,
	output logic read_denied,
	output logic irq_suppress,
	output logic [7:0] load_data,
	output logic load_valid,
	output logic ext_prog_lock,
	output logic ext_verify_lock
);

	// all block state
	typedef struct packed
	{
		spfc_state_t st;
		logic [7:0] ctrl;
		logic [2:0] win;
		logic [31:0] prog_cnt;
		logic prog_no_read_while_write_section;
		logic [5:0] lock;
		spfc_req_t req;
		logic [7:0] fuse_lo;
		logic [PAGE_WORDS-1:0] buf_vld;
		logic loading;
		logic [7:0] rejects;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
		logic stall;
		logic blocked;
		logic denied;
		logic suppress;
		logic [7:0] ld_data;
		logic ld_vld;
		logic xprog;
		logic xver;
	} spfc_s_t;

	spfc_s_t s_q;
	spfc_s_t s_d;

	// address of pointer words and section test
	function automatic logic in_boot(input logic [15:0] z);
		in_boot = z[12:1] >= SPFC_NO_READ_WHILE_WRITE_SECTION_START;
	endfunction : in_boot

	function automatic logic store_denied(input logic [5:0] lk,
		input logic boot_tgt);
		logic [1:0] f;
		f = boot_tgt ? lk[5:4] : lk[3:2];
		store_denied = ~f[0]; // RQ20 RQ23
	endfunction : store_denied

	logic acc;
	logic wr;
	logic [4:0] low5;
	logic legal;
	logic busy_op;
	// store strobe of the current access, seen in the cycle it is taken
	logic st_now;

	// next-state logic
	always_comb
	begin
		s_d = s_q;
		acc = psel & penable;
		wr = acc & pwrite;
		low5 = pwdata[4:0];
		legal = low5 == SPFC_P_RE || low5 == SPFC_P_BLS
			|| low5 == SPFC_P_PW || low5 == SPFC_P_PE
			|| low5 == SPFC_P_SE; // RQ17
		busy_op = s_q.st == SPFC_PROG;
		// a registered strobe would land one cycle past the arming window
		st_now = wr && !s_q.pready && paddr == SPFC_STAT_OFF; // RQ5 RQ15
		s_d.pready = acc & ~s_q.pready;
		s_d.pslverr = 1'b0;
		s_d.ld_vld = 1'b0;
		// apb writes
		if (wr && !s_q.pready)
		begin
			case (paddr)
				SPFC_CTRL_OFF:
				begin
					s_d.ctrl[SPFC_B_IE] = pwdata[SPFC_B_IE];
					if (legal && !busy_op) // RQ17 RQ6
					begin
						s_d.ctrl[4:0] = low5;
						s_d.st = SPFC_ARMED;
						s_d.win = SPFC_ARM_CYC; // RQ24
						if (low5 == SPFC_P_RE && s_q.loading)
							s_d.loading = 1'b0; // RQ7
					end
				end
				SPFC_PTR_OFF: s_d.req.ptr = pwdata[15:0];
				SPFC_DATA_OFF: s_d.req.word = pwdata[15:0];
				SPFC_FUSE_OFF: s_d.fuse_lo = pwdata[7:0];
				SPFC_LOCK_OFF, SPFC_STAT_OFF: ;
				default: s_d.pslverr = 1'b1;
			endcase
		end
		else if (acc && !s_q.pready)
		begin
			case (paddr)
				SPFC_CTRL_OFF, SPFC_LOCK_OFF, SPFC_PTR_OFF,
				SPFC_DATA_OFF, SPFC_FUSE_OFF, SPFC_STAT_OFF: ;
				default: s_d.pslverr = 1'b1;
			endcase
		end
		// reads; control register bit 5 reads zero
		case (paddr)
			SPFC_CTRL_OFF: s_d.prdata = {24'h0, s_q.ctrl & 8'hdf}; // RQ17
			SPFC_LOCK_OFF: s_d.prdata = {26'h0, s_q.lock};
			SPFC_PTR_OFF: s_d.prdata = {16'h0, s_q.req.ptr};
			SPFC_DATA_OFF: s_d.prdata = {16'h0, s_q.req.word};
			SPFC_FUSE_OFF: s_d.prdata = {24'h0, s_q.fuse_lo};
			// status word keeps the low buffer valid bits and the reject count
			SPFC_STAT_OFF: s_d.prdata = 32'({s_q.buf_vld, s_q.rejects});
			default: s_d.prdata = 32'h0;
		endcase
		// sequencer
		case (s_q.st)
			SPFC_IDLE: ;
			SPFC_ARMED:
			begin
				if (s_q.win == 3'h0)
				begin
					s_d.ctrl[4:0] = 5'h00; // RQ12 RQ15
					s_d.st = SPFC_IDLE;
				end
				else
					s_d.win = s_q.win - 3'h1;
				if (s_q.win != 3'h0 && s_q.ctrl[SPFC_B_BLS] && rww_read
					&& (SPFC_ARM_CYC - s_q.win) < SPFC_LPM_CYC)
				begin
					s_d.ld_vld = 1'b1; // RQ9
					s_d.ld_data = s_q.req.ptr[0]
						? s_q.fuse_lo : {2'h3, s_q.lock};
				end
				if (s_q.win != 3'h0 && st_now)
				begin
					s_d.st = SPFC_IDLE;
					s_d.ctrl[4:0] = 5'h00; // RQ15
					case (s_q.ctrl[4:0])
						SPFC_P_RE:
						begin
							s_d.blocked = 1'b0; // RQ3 RQ5
							s_d.ctrl[SPFC_B_BUSY] = 1'b0;
							s_d.buf_vld = '0; // RQ7
						end
						SPFC_P_BLS:
							s_d.lock = s_q.lock & s_q.req.word[5:0]; // RQ8 RQ18
						SPFC_P_PW, SPFC_P_PE:
						begin
							if (store_denied(s_q.lock, in_boot(s_q.req.ptr)))
								s_d.rejects = s_q.rejects + 8'h01;
							else
							begin
								s_d.st = SPFC_PROG; // RQ10 RQ11
								s_d.ctrl[4:0] = s_q.ctrl[4:0]; // RQ16
								s_d.prog_cnt = PROG_CYC[31:0];
								s_d.prog_no_read_while_write_section = in_boot(s_q.req.ptr);
								if (!in_boot(s_q.req.ptr))
								begin
									s_d.ctrl[SPFC_B_BUSY] = 1'b1; // RQ2
									s_d.blocked = 1'b1;
								end
								if (s_q.ctrl[SPFC_B_PW])
									s_d.buf_vld = '0;
							end
						end
						SPFC_P_SE:
						begin
							s_d.ctrl[SPFC_B_BUSY] = 1'b0; // RQ4
							s_d.blocked = 1'b0;
							s_d.loading = 1'b1;
							s_d.buf_vld[s_q.req.ptr[5:1]] = 1'b1; // RQ14
						end
						default: ;
					endcase
				end
			end
			SPFC_PROG:
			begin
				if (s_q.prog_cnt == 32'h1)
				begin
					s_d.st = SPFC_IDLE;
					s_d.ctrl[4:0] = 5'h00; // RQ12 RQ16
				end
				s_d.prog_cnt = s_q.prog_cnt - 32'h1;
			end
			default: s_d.st = SPFC_IDLE;
		endcase
		s_d.stall = s_d.st == SPFC_PROG && s_d.prog_no_read_while_write_section; // RQ13
		s_d.irq = s_d.ctrl[SPFC_B_IE] & global_int_en
			& ~s_d.ctrl[SPFC_B_SE]; // RQ1
		s_d.denied = exec_in_boot ? ~s_q.lock[3] : ~s_q.lock[5]; // RQ21 RQ23
		s_d.suppress = exec_in_boot ? (~s_q.lock[5] & ~vec_in_boot)
			: (~s_q.lock[3] & vec_in_boot); // RQ21 RQ23
		s_d.xprog = ~s_q.lock[0]; // RQ19
		s_d.xver = ~s_q.lock[0] & ~s_q.lock[1]; // RQ19
		s_d.req.store = st_now;
	end

	// register stage
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s_q <= '0;
			s_q.st <= SPFC_IDLE;
			s_q.ctrl <= SPFC_CTRL_RST; // RQ24
			s_q.lock <= SPFC_LOCK_RST; // RQ18
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// outputs straight from flops
	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign ready_irq = s_q.irq;
	assign core_stall = s_q.stall;
	assign rww_blocked = s_q.blocked;
	assign read_denied = s_q.denied;
	assign irq_suppress = s_q.suppress;
	assign load_data = s_q.ld_data;
	assign load_valid = s_q.ld_vld;
	assign ext_prog_lock = s_q.xprog;
	assign ext_verify_lock = s_q.xver;

endmodule : spfc_ctrl

// ===== verification/spfc_ctrl_properties.sv
// port checker for the self-program flash control block
`timescale 1ns/100ps
module spfc_ctrl_properties
#(
	parameter int PROG_CYC = 40
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// core side
	input wire logic global_int_en,
	input wire logic rww_read,
	input wire logic ready_irq,
	input wire logic core_stall,
	input wire logic load_valid,
	input wire logic ext_prog_lock,
	input wire logic ext_verify_lock
);
	logic [31:0] stall_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// length of the current core stall
	always_ff @(posedge clk)
	begin
		if (!rst_n || !core_stall)
			stall_q <= '0;
		else
			stall_q <= stall_q + 32'h1;
	end
	a_pready_pulse: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	a_pready_cause: assert property (pready |-> $past(psel && penable))
		else $error("pready without an access phase");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr outside pready");
	a_irq_gie: assert property (ready_irq |-> $past(global_int_en))
		else $error("ready interrupt without global flag");
	a_irq_prog: assert property (core_stall && $past(core_stall) |-> !ready_irq)
		else $error("ready interrupt during programming");
	a_stall_bound: assert property (stall_q <= PROG_CYC + 4)
		else $error("core stall lasts too long");
	a_load_cause: assert property (load_valid |-> $past(rww_read))
		else $error("load result without a load");
	a_lock_order: assert property (ext_verify_lock |-> ext_prog_lock)
		else $error("verify lock without program lock");
	c_stall: cover property (core_stall);
	c_load: cover property (load_valid);
	c_irq: cover property (ready_irq);
endmodule : spfc_ctrl_properties
bind spfc_ctrl spfc_ctrl_properties #(.PROG_CYC(PROG_CYC)) u_props (.clk,
	.rst_n, .psel, .penable, .pready, .pslverr, .global_int_en, .rww_read,
	.ready_irq, .core_stall, .load_valid, .ext_prog_lock, .ext_verify_lock);

// ===== verification/spfc_core_model.sv
// processor core stand-in issuing loads and status levels
`timescale 1ns/100ps
module spfc_core_model
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// requests from the bench
	input wire logic lpm_req,
	input wire logic [1:0] lpm_dly,
	input wire logic [2:0] mode,
	// core levels toward the block
	output logic global_int_en,
	output logic exec_in_boot,
	output logic vec_in_boot,
	output logic rww_read
);
	logic busy_q;
	logic [1:0] cnt_q;
	// status levels follow the mode word
	assign {global_int_en, exec_in_boot, vec_in_boot} = mode;
	// load issued after a chosen delay, one cycle long
	assign rww_read = busy_q && cnt_q == 2'h0;
	always_ff @(posedge clk)
	begin
		if (!rst_n || rww_read)
			busy_q <= 1'b0;
		else if (lpm_req)
		begin
			busy_q <= 1'b1;
			cnt_q <= lpm_dly;
		end
		else if (busy_q)
			cnt_q <= cnt_q - 2'h1;
	end
endmodule : spfc_core_model

// ===== verification/tb_spfc_ctrl.sv
// self-checking bench for the self-program flash control block
`timescale 1ns/100ps
module tb_spfc_ctrl
	import spfc_pkg::*;
;
	logic clk, rst_n, psel, penable, pwrite, lpm_req, err, hit;
	logic pready, pslverr, ready_irq, core_stall, rww_blocked, read_denied;
	logic irq_suppress, load_valid, ext_prog_lock, ext_verify_lock;
	logic global_int_en, exec_in_boot, vec_in_boot, rww_read;
	logic [7:0] paddr, load_data;
	logic [31:0] pwdata, prdata, rd, v;
	logic [2:0] mode;
	int bad_count, num_checks, cyc;
	spfc_ctrl #(.PROG_CYC(40)) u_spfc_ctrl (.clk, .rst_n, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .global_int_en,
		.exec_in_boot, .vec_in_boot, .rww_read, .ready_irq, .core_stall,
		.rww_blocked, .read_denied, .irq_suppress, .load_data, .load_valid,
		.ext_prog_lock, .ext_verify_lock);
	spfc_core_model u_spfc_core_model (.clk, .rst_n, .lpm_req,
		.lpm_dly(2'h0), .mode, .global_int_en, .exec_in_boot, .vec_in_boot,
		.rww_read);
	// clock and hang guard
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			bad_count++;
			wrap_up();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk iff pready === 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task op(input logic [7:0] pat, input logic [15:0] z);
		apb(1'b1, SPFC_PTR_OFF, {16'h0, z});
		apb(1'b1, SPFC_CTRL_OFF, {24'h0, pat});
		apb(1'b1, SPFC_STAT_OFF, 32'h0);
	endtask : op
	task idle;
		repeat (80)
		begin
			apb(1'b0, SPFC_CTRL_OFF, 32'h0);
			if (rd[0] === 1'b0)
				break;
		end
	endtask : idle
	task wrap_up;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	function automatic logic legal(input logic [4:0] p);
		return p inside {SPFC_P_RE, SPFC_P_BLS, SPFC_P_PW, SPFC_P_PE, SPFC_P_SE};
	endfunction : legal
	// main sequence
	initial
	begin
		{psel, penable, pwrite, lpm_req, rst_n} = '0;
		paddr = '0;
		pwdata = '0;
		mode = 3'h0;
		{bad_count, num_checks, cyc} = '0;
		v = $urandom(32'h9d4cc2b9);
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, SPFC_CTRL_OFF, 32'h0);
		chk(rd[7:0], SPFC_CTRL_RST);
		apb(1'b0, SPFC_LOCK_OFF, 32'h0);
		chk(rd[5:0], SPFC_LOCK_RST);
		apb(1'b0, 8'h18, 32'h0);
		chk(err, 1'b1);
		repeat (8)
		begin
			v = $urandom;
			if (!legal(v[4:0]))
				apb(1'b1, SPFC_CTRL_OFF, {27'h1, v[4:0]});
			apb(1'b0, SPFC_CTRL_OFF, 32'h0);
			chk(rd[7:0], 8'h00);
		end
		apb(1'b1, SPFC_CTRL_OFF, 32'h23);
		repeat (8) @(posedge clk);
		apb(1'b0, SPFC_CTRL_OFF, 32'h0);
		chk(rd[7:0], 8'h00);
		$display("register test done");
		op(8'h03, 16'h0);
		@(negedge clk);
		chk(rww_blocked, 1'b1);
		apb(1'b0, SPFC_CTRL_OFF, 32'h0);
		chk({rd[6], rd[0]}, 2'b11);
		op(8'h11, 16'h0);
		apb(1'b0, SPFC_CTRL_OFF, 32'h0);
		chk(rd[6], 1'b1);
		idle();
		op(8'h11, 16'h0);
		apb(1'b0, SPFC_CTRL_OFF, 32'h0);
		chk(rd[6], 1'b0);
		op(8'h03, 16'h0);
		idle();
		apb(1'b1, SPFC_DATA_OFF, $urandom);
		op(8'h01, 16'h0002);
		apb(1'b0, SPFC_CTRL_OFF, 32'h0);
		chk(rd[6], 1'b0);
		apb(1'b0, SPFC_STAT_OFF, 32'h0);
		chk(rd[9], 1'b1);
		op(8'h05, 16'h1800);
		@(negedge clk);
		chk(core_stall, 1'b1);
		idle();
		chk(core_stall, 1'b0);
		$display("programming test done");
		v = $urandom;
		apb(1'b1, SPFC_FUSE_OFF, {24'h0, v[7:0]});
		apb(1'b1, SPFC_PTR_OFF, 32'h1);
		apb(1'b1, SPFC_CTRL_OFF, 32'h09);
		lpm_req <= 1'b1;
		@(posedge clk);
		lpm_req <= 1'b0;
		hit = 1'b0;
		repeat (6) @(negedge clk)
		begin
			if (load_valid === 1'b1)
			begin
				hit = 1'b1;
				rd = {24'h0, load_data};
			end
		end
		chk(hit, 1'b1);
		chk(rd[7:0], v[7:0]);
		@(posedge clk);
		mode <= 3'h4;
		apb(1'b1, SPFC_CTRL_OFF, 32'h81);
		repeat (8) @(posedge clk);
		chk(ready_irq, 1'b1);
		mode <= 3'h1;
		repeat (3) @(posedge clk);
		chk(ready_irq, 1'b0);
		apb(1'b1, SPFC_DATA_OFF, 32'hf0);
		op(8'h09, 16'h0);
		idle();
		apb(1'b0, SPFC_LOCK_OFF, 32'h0);
		chk(rd[5:0], 6'h30);
		chk({ext_prog_lock, ext_verify_lock}, 2'b11);
		chk(irq_suppress, 1'b1);
		op(8'h03, 16'h0);
		apb(1'b0, SPFC_CTRL_OFF, 32'h0);
		chk(rd[6], 1'b0);
		apb(1'b0, SPFC_STAT_OFF, 32'h0);
		chk(rd[7:0], 8'h01);
		$display("lock test done");
		wrap_up();
	end
endmodule : tb_spfc_ctrl
